// ---- sim/ac_ctrl_model.sv ----
// Behavioural link controller: bit clock, frame sync, commands, frame capture
`timescale 1ns/1ps
module ac_ctrl_model (
  output logic      BIT_CLK_OUT,
  output logic      SYNC_OUT,
  output logic      SDATA_OUT,
  input  wire logic SDATA_IN
);
  initial begin
    BIT_CLK_OUT = 1'b0;
    SYNC_OUT    = 1'b0;
    SDATA_OUT   = 1'b0;
  end
  // Clock stands still between frames
  task automatic send_frame(input logic [55:0] cmd, output logic [255:0] rx);
    #7;
    for (int r = 0; r < 257; r++) begin
      #100 BIT_CLK_OUT = 1'b1;
      // sync rises on a clock rise
      SYNC_OUT = (r < 16);
      SDATA_OUT = (r >= 1 && r <= 56) ? cmd[56-r] : 1'b0;
      #100 BIT_CLK_OUT = 1'b0;
      if (r > 0) rx[256-r] = SDATA_IN;
    end
  endtask
endmodule // ac_ctrl_model

// ---- sim/tb_ac_link_input_frame.sv ----
// Self-checking bench for the link input frame builder
`timescale 1ns/1ps
module tb_ac_link_input_frame;
  localparam int RDY = 4000;
  logic         clk, nrst, bclk, sync, sdo, sdi;
  logic [5:0]   awaddr, araddr;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [31:0]  wdata, rdata, seed, rd, lft, rgt;
  logic [1:0]   bresp, rresp, rs, id;
  logic [255:0] rx;
  logic [9:0]   need;
  logic [15:0]  rate;
  int           err_count, n_compared, cyc, p;

  ac_link_input_frame #(.READY_CYCLES(RDY)) DUT (
    .REF_CLK_IN(clk), .NRST_IN(nrst), .BIT_CLK_IN(bclk), .SYNC_IN(sync),
    .SDATA_OUT_IN(sdo), .SDATA_IN_OUT(sdi), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready));
  ac_ctrl_model ctl (.BIT_CLK_OUT(bclk), .SYNC_OUT(sync), .SDATA_OUT(sdo), .SDATA_IN(sdi));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [55:0] rdc(input logic [6:0] ix);
    return {16'hC000, 1'b1, ix, 32'h0};
  endfunction

  function automatic logic [55:0] wrc(input logic [6:0] ix, input logic [15:0] d);
    return {16'hE000, 1'b0, ix, 12'h0, d, 4'h0};
  endfunction

  // Whole expected frame: tags, slot 1, slot 2, record pair, zeros elsewhere
  function automatic logic [255:0] expf(input logic rdy, rv, ven, input logic [6:0] ix,
                                         input logic [15:0] d, input int p);
    logic [255:0] f;
    int           sl;
    int           sr;
    sl = p == 0 ? 3 : p == 1 ? 6 : p == 2 ? 7 : 10;
    sr = p == 0 ? 4 : p == 1 ? 9 : p == 2 ? 8 : 11;
    f = '0;
    f[255] = rdy;
    f[254] = rv;
    f[253] = rv;
    f[238 -: 7] = rv ? ix : 7'h00;
    f[219 -: 20] = rv ? {d, 4'h0} : 20'h0;
    for (int g = 0; g < 10; g++)
      f[231-g] = ven && rdy && (g + 3 == sl || g + 3 == sr) && !need[g];
    if (rdy) begin
      f[255-sl] = 1'b1;
      f[255-sr] = 1'b1;
      f[259-20*sl -: 20] = lft[19:0];
      f[259-20*sr -: 20] = rgt[19:0];
    end
    return f;
  endfunction

  task automatic chk(input string nm, input logic [255:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Whole captured frame against the expected one, index echo included
  task automatic cf(input string nm, input logic rdy, rv, ven, input logic [6:0] ix,
                    input logic [15:0] d, input int p);
    chk(nm, expf(rdy, rv, ven, ix, d, p), rx);
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      b = bvalid && !aw && !w;
      r = bresp;
      aw = aw && !awready;
      w = w && !wready;
      @(posedge clk);
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic g, t;
    g = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!g) begin
      @(negedge clk);
      g = rvalid && !arvalid;
      t = arready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    {nrst, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    seed = 32'h00000025;
    need = 10'h000;
    lft = 32'h0;
    rgt = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    ctl.send_frame(56'h0, rx);
    cf("idle frame", 1'b0, 1'b0, 1'b0, 7'h00, 16'h0, 0);
    for (int i = 0; i < 2 && rx[255] !== 1'b1; i++) ctl.send_frame(56'h0, rx);
    cf("ready frame", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 0);
    axr(6'h04, rd, rs);
    chk("status ready", 1'b1, rd[0]);
    axr(6'h18, rd, rs);
    chk("unmapped rresp", 2'h2, rs);
    axw(6'h18, 32'h0, rs);
    chk("unmapped bresp", 2'h2, rs);
    ctl.send_frame(rdc(7'h26), rx);
    cf("read cmd frame", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 0);
    ctl.send_frame(56'h0, rx);
    cf("power reply", 1'b1, 1'b1, 1'b0, 7'h26, 16'h000F, 0);
    $display("test ready and reply done");
    seed = xs(seed);
    lft = {12'h0, seed[19:0]};
    axw(6'h08, lft, rs);
    seed = xs(seed);
    rgt = {12'h0, seed[19:0]};
    axw(6'h0C, rgt, rs);
    seed = xs(seed);
    need = seed[9:0];
    rate = seed[31:16] | 16'h0001;
    axw(6'h10, {22'h0, need}, rs);
    axr(6'h08, rd, rs);
    chk("left readback", lft, rd);
    ctl.send_frame(wrc(7'h2A, 16'h0001), rx);
    ctl.send_frame(wrc(7'h2C, rate), rx);
    for (p = 0; p < 4; p++) begin
      ctl.send_frame(wrc(7'h6E, 16'(p << 4)), rx);
      ctl.send_frame(56'h0, rx);
      cf("pair frame", 1'b1, 1'b0, 1'b1, 7'h00, 16'h0, p);
    end
    ctl.send_frame(wrc(7'h2A, 16'h0000), rx);
    ctl.send_frame(56'h0, rx);
    cf("fixed rate", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 3);
    ctl.send_frame(wrc(7'h2A, 16'h0001), rx);
    ctl.send_frame(wrc(7'h2C, 16'hBB80), rx);
    ctl.send_frame(56'h0, rx);
    cf("48k rate", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 3);
    $display("test record and requests done");
    seed = xs(seed);
    id = seed[1:0] == 2'h0 ? 2'h2 : seed[1:0];
    axw(6'h00, {29'h0, id, 1'b0}, rs);
    ctl.send_frame({14'h2000, id, 1'b1, 7'h26, 32'h0}, rx);
    ctl.send_frame({14'h2000, ~id, 1'b1, 7'h26, 32'h0}, rx);
    cf("second reply", 1'b1, 1'b1, 1'b0, 7'h26, 16'h000F, 3);
    ctl.send_frame(56'h0, rx);
    cf("wrong id", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 3);
    ctl.send_frame({14'h2000, id, 1'b0, 7'h2C, 12'h0, rate, 4'h0}, rx);
    axr(6'h14, rd, rs);
    chk("view readback", {13'h0, 2'h3, 1'b1, rate}, rd);
    $display("test device select done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    lft = 32'h0;
    rgt = 32'h0;
    need = 10'h000;
    axw(6'h00, 32'h1, rs);
    ctl.send_frame(56'h0, rx);
    cf("reset frame", 1'b0, 1'b0, 1'b0, 7'h00, 16'h0, 0);
    ctl.send_frame(56'h0, rx);
    cf("settled ready", 1'b1, 1'b0, 1'b0, 7'h00, 16'h0, 0);
    $display("test reset and settle done");
    print_verdict();
  end
endmodule // tb_ac_link_input_frame

// ---- verilog/ac_link_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the input frame builder
`ifndef AC_LINK_CFG_SVH
`define AC_LINK_CFG_SVH

// ****************************************
// Bus register offsets
// ****************************************
`define OFS_CTRL        6'h00
`define OFS_STATUS      6'h04
`define OFS_LEFT        6'h08
`define OFS_RIGHT       6'h0C
`define OFS_NEED        6'h10
`define OFS_VIEW        6'h14

// ****************************************
// Bus register fields
// ****************************************
`define CTRL_SETTLED_BIT   0
`define CTRL_SEL_LSB       1
`define STAT_READY_BIT     0
`define STAT_RESP_BIT      1
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// ****************************************
// Link register indices and fields
// ****************************************
`define IDX_POWER       7'h26
`define IDX_EXT_CTRL    7'h2A
`define IDX_DAC_RATE    7'h2C
`define IDX_SLOT_ASSIGN 7'h6E
`define VAR_RATE_BIT    0
`define DAC_PAIR_LSB    4
`define EXT_CTRL_RST    16'h0000
`define DAC_RATE_RST    16'hBB80
`define SLOT_ASSIGN_RST 16'h0000
`define RATE_48K        16'hBB80

// ****************************************
// Frame layout
// ****************************************
`define TAG_READY_BIT   15
`define TAG_BITS        5'h0F
`define SLOT_MSB        5'h13
`define LAST_SLOT       4'hC
`define CMD_BITS        6'h38

// ****************************************
// Timing
// ****************************************
`define REF_CLK_HZ      64'd40000000
`define READY_TIME_MS   64'd400
`define READY_CYCLES    ((`READY_TIME_MS * `REF_CLK_HZ) / 64'd1000)

`endif

// ---- verilog/ac_link_input_frame.sv ----
// Device-side builder of the link input frame with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "ac_link_cfg.svh"
module ac_link_input_frame #(
  parameter int unsigned READY_CYCLES = 32'(`READY_CYCLES)
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        BIT_CLK_IN,
  input  wire logic        SYNC_IN,
  input  wire logic        SDATA_OUT_IN,
  output logic             SDATA_IN_OUT,
  input  wire logic [5:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [5:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN
);

  // ****************************************
  // Pin sampling and edge detection
  // ****************************************
  logic [2:0]  pins_s;
  logic        bclk_d_q;
  logic        sync_prev_q;
  logic        rise_evt;
  logic        fall_evt;
  logic        frame_start;

  pin_sync u_sync (
    .clk_in   (REF_CLK_IN),
    .nrst_in  (NRST_IN),
    .pins_in  ({BIT_CLK_IN, SYNC_IN, SDATA_OUT_IN}),
    .pins_out (pins_s)
  );

  assign rise_evt    = pins_s[2] & ~bclk_d_q;
  assign fall_evt    = ~pins_s[2] & bclk_d_q;
  // SYNC rise seen at a falling edge
  assign frame_start = fall_evt & pins_s[1] & ~sync_prev_q;

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      bclk_d_q    <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      bclk_d_q <= pins_s[2];
      if (fall_evt) begin
        sync_prev_q <= pins_s[1];
      end
    end
  end

  // ****************************************
  // Bus-visible state
  // ****************************************
  logic        settled_q;
  logic [1:0]  dev_sel_q;
  logic [19:0] left_q;
  logic [19:0] right_q;
  logic [9:0]  need_q;
  logic        link_ready_q;
  logic        resp_pend_q;
  logic [15:0] ext_ctrl_q;
  logic [15:0] dac_rate_q;
  logic [15:0] slot_assign_q;

  // ****************************************
  // Link ready
  // ****************************************
  logic        sync_seen_q;
  logic [31:0] ready_cnt_q;

  // Forced ready after the settle limit
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sync_seen_q  <= 1'b0;
      ready_cnt_q  <= 32'h0;
      link_ready_q <= 1'b0;
    end else begin
      if (frame_start) begin
        sync_seen_q <= 1'b1;
      end
      if (sync_seen_q && ready_cnt_q < READY_CYCLES) begin
        ready_cnt_q <= ready_cnt_q + 32'h1;
      end
      if (sync_seen_q && (settled_q || ready_cnt_q >= READY_CYCLES)) begin
        link_ready_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Command receive
  // ****************************************
  logic [55:0] rx_sh_q;
  logic [5:0]  rx_cnt_q;
  logic        cmd_done_q;
  logic [15:0] rx_tag;
  logic [19:0] rx_s1;
  logic [19:0] rx_s2;
  logic        hit;
  logic        do_write;
  logic        do_read;
  logic [6:0]  resp_idx_q;
  logic [15:0] resp_data_q;
  logic [15:0] reg_rdata;

  assign rx_tag = rx_sh_q[55:40];
  assign rx_s1  = rx_sh_q[39:20];
  assign rx_s2  = rx_sh_q[19:0];

  // Receive counter restarted at frame start
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_sh_q    <= 56'h0;
      rx_cnt_q   <= `CMD_BITS;
      cmd_done_q <= 1'b0;
    end else begin
      cmd_done_q <= 1'b0;
      if (frame_start) begin
        rx_cnt_q <= 6'h0;
      end else if (fall_evt && rx_cnt_q < `CMD_BITS) begin
        rx_sh_q  <= {rx_sh_q[54:0], pins_s[0]};
        rx_cnt_q <= rx_cnt_q + 6'h1;
        cmd_done_q <= (rx_cnt_q == `CMD_BITS - 6'h1);
      end
    end
  end

  // Primary access by tags and zero ID
  always_comb begin
    hit      = 1'b0;
    do_write = 1'b0;
    if (dev_sel_q == 2'h0) begin
      hit      = rx_tag[15] & rx_tag[14] & (rx_tag[1:0] == 2'h0);
      do_write = hit & rx_tag[13] & ~rx_s1[19];
    end else begin
      hit      = rx_tag[15] & (rx_tag[1:0] == dev_sel_q);
      do_write = hit & ~rx_s1[19];
    end
    do_read = hit & rx_s1[19];
  end

  always_comb begin
    case (rx_s1[18:12])
      `IDX_POWER:       reg_rdata = {12'h000, {4{link_ready_q}}};
      `IDX_EXT_CTRL:    reg_rdata = ext_ctrl_q;
      `IDX_DAC_RATE:    reg_rdata = dac_rate_q;
      `IDX_SLOT_ASSIGN: reg_rdata = slot_assign_q;
      default:          reg_rdata = 16'h0000;
    endcase
  end

  // Write data from output slot 2
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ext_ctrl_q    <= `EXT_CTRL_RST;
      dac_rate_q    <= `DAC_RATE_RST;
      slot_assign_q <= `SLOT_ASSIGN_RST;
    end else if (cmd_done_q && do_write) begin
      case (rx_s1[18:12])
        `IDX_EXT_CTRL:    ext_ctrl_q    <= rx_s2[19:4];
        `IDX_DAC_RATE:    dac_rate_q    <= rx_s2[19:4];
        `IDX_SLOT_ASSIGN: slot_assign_q <= rx_s2[19:4];
        default:          ext_ctrl_q    <= ext_ctrl_q;
      endcase
    end
  end

  // Read reply kept for the next frame
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      resp_pend_q <= 1'b0;
      resp_idx_q  <= 7'h00;
      resp_data_q <= 16'h0000;
    end else if (cmd_done_q && do_read) begin
      resp_pend_q <= 1'b1;
      resp_idx_q  <= rx_s1[18:12];
      resp_data_q <= reg_rdata;
    end else if (frame_start) begin
      resp_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Sample request flags
  // ****************************************
  ac_link_pkg::slot_pair_type dac_pair;
  logic [9:0]  slot_req;
  logic        rate_var;
  logic        variable_rate_enable;

  assign dac_pair = ac_link_pkg::slot_pair_type'(slot_assign_q[`DAC_PAIR_LSB +: 2]);
  assign variable_rate_enable = ext_ctrl_q[`VAR_RATE_BIT];
  assign rate_var = (dac_rate_q != `RATE_48K);

  function automatic logic in_pair(input logic [3:0] slot, input logic [1:0] pair);
    logic r;
    case (pair)
      2'h0:    r = (slot == 4'h3) | (slot == 4'h4);
      2'h1:    r = (slot == 4'h6) | (slot == 4'h9);
      2'h2:    r = (slot == 4'h7) | (slot == 4'h8);
      default: r = (slot == 4'hA) | (slot == 4'hB);
    endcase
    return r;
  endfunction

  // Flag 9-g belongs to output slot 3+g
  for (genvar g = 0; g < 10; g++) begin : g_req
    // Zero when fixed rate or powered down
    // Set only when its need bit is clear
    assign slot_req[9-g] = variable_rate_enable & link_ready_q & rate_var & ~need_q[g] &
                           in_pair(4'(g + 3), dac_pair);
  end

  // ****************************************
  // Frame transmit
  // ****************************************
  ac_link_pkg::tx_state_type tx_state_q;
  logic [3:0]  tx_slot_q;
  logic [4:0]  tx_bit_q;
  logic [15:0] tag_q;
  logic [19:0] s1_q;
  logic [19:0] s2_q;
  logic [19:0] left_f_q;
  logic [19:0] right_f_q;
  logic [1:0]  pair_f_q;
  logic [19:0] cur_word;
  logic [3:0]  left_slot;
  logic [3:0]  right_slot;
  logic [15:0] tag_d;

  always_comb begin
    case (pair_f_q)
      2'h0:    {left_slot, right_slot} = {4'h3, 4'h4};
      2'h1:    {left_slot, right_slot} = {4'h6, 4'h9};
      2'h2:    {left_slot, right_slot} = {4'h7, 4'h8};
      default: {left_slot, right_slot} = {4'hA, 4'hB};
    endcase
  end

  // Tag bits for reply and record slots
  // Slot 1/2 tags only with read reply
  always_comb begin
    tag_d = 16'h0000;
    tag_d[`TAG_READY_BIT] = link_ready_q;
    tag_d[14] = link_ready_q & resp_pend_q;
    tag_d[13] = link_ready_q & resp_pend_q;
    case (slot_assign_q[`DAC_PAIR_LSB +: 2])
      2'h0:    tag_d[12:11] = {2{link_ready_q}};
      2'h1:    {tag_d[9], tag_d[6]} = {2{link_ready_q}};
      2'h2:    tag_d[8:7] = {2{link_ready_q}};
      default: tag_d[5:4] = {2{link_ready_q}};
    endcase
  end

  // Frame contents frozen at the start so a frame is self-consistent
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tag_q     <= 16'h0000;
      s1_q      <= 20'h00000;
      s2_q      <= 20'h00000;
      left_f_q  <= 20'h00000;
      right_f_q <= 20'h00000;
      pair_f_q  <= 2'h0;
    end else if (frame_start) begin
      tag_q     <= tag_d;
      // Index echo and request flags in slot 1
      s1_q      <= {1'b0, tag_d[14] ? resp_idx_q : 7'h00, slot_req, 2'h0};
      // Read data only when tagged valid
      s2_q      <= tag_d[13] ? {resp_data_q, 4'h0} : 20'h00000;
      left_f_q  <= link_ready_q ? left_q : 20'h00000;
      right_f_q <= link_ready_q ? right_q : 20'h00000;
      pair_f_q  <= slot_assign_q[`DAC_PAIR_LSB +: 2];
    end
  end

  // Record pair chosen by slot assignment
  // Slot 5 and other slots stuffed zero
  always_comb begin
    if (tx_slot_q == 4'h0) begin
      cur_word = {4'h0, tag_q};
    end else if (tx_slot_q == 4'h1) begin
      cur_word = s1_q;
    end else if (tx_slot_q == 4'h2) begin
      cur_word = s2_q;
    end else if (tx_slot_q == left_slot) begin
      cur_word = left_f_q;
    end else if (tx_slot_q == right_slot) begin
      cur_word = right_f_q;
    end else begin
      cur_word = 20'h00000;
    end
  end

  // One bit per rising edge after start
  // Slot and bit counters restarted each frame
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_state_q   <= ac_link_pkg::TX_IDLE;
      tx_slot_q    <= 4'h0;
      tx_bit_q     <= `TAG_BITS;
      SDATA_IN_OUT <= 1'b0;
    end else if (frame_start) begin
      tx_state_q <= ac_link_pkg::TX_SEND;
      tx_slot_q  <= 4'h0;
      tx_bit_q   <= `TAG_BITS;
    end else if (rise_evt) begin
      case (tx_state_q)
        ac_link_pkg::TX_SEND: begin
          // MSB first from the current word
          SDATA_IN_OUT <= cur_word[tx_bit_q];
          // 16 tag bits then 20 per slot
          if (tx_bit_q != 5'h0) begin
            tx_bit_q <= tx_bit_q - 5'h1;
          end else if (tx_slot_q == `LAST_SLOT) begin
            tx_state_q <= ac_link_pkg::TX_IDLE;
          end else begin
            tx_slot_q <= tx_slot_q + 4'h1;
            tx_bit_q  <= `SLOT_MSB;
          end
        end
        default: SDATA_IN_OUT <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic        aw_held_q;
  logic        w_held_q;
  logic [5:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic        wr_map;
  logic [31:0] rd_word;
  logic        rd_map;

  assign S_AXI_AWREADY_OUT = ~aw_held_q & ~S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = ~w_held_q & ~S_AXI_BVALID_OUT;
  assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;
  assign wr_go  = aw_held_q & w_held_q;
  assign wr_map = (awaddr_q == `OFS_CTRL) | (awaddr_q == `OFS_LEFT) |
                  (awaddr_q == `OFS_RIGHT) | (awaddr_q == `OFS_NEED);

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      aw_held_q        <= 1'b0;
      w_held_q         <= 1'b0;
      awaddr_q         <= 6'h00;
      wdata_q          <= 32'h0;
      wstrb_q          <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {S_AXI_AWADDR_IN[5:2], 2'h0};
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_IN;
        wstrb_q  <= S_AXI_WSTRB_IN;
      end
      if (wr_go) begin
        aw_held_q        <= 1'b0;
        w_held_q         <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      settled_q <= 1'b0;
      dev_sel_q <= 2'h0;
      left_q    <= 20'h00000;
      right_q   <= 20'h00000;
      need_q    <= 10'h000;
    end else if (wr_go) begin
      case (awaddr_q)
        `OFS_CTRL: begin
          if (wstrb_q[0]) begin
            settled_q <= wdata_q[`CTRL_SETTLED_BIT];
            dev_sel_q <= wdata_q[`CTRL_SEL_LSB +: 2];
          end
        end
        `OFS_LEFT:  left_q  <= wdata_q[19:0];
        `OFS_RIGHT: right_q <= wdata_q[19:0];
        `OFS_NEED:  need_q  <= wdata_q[9:0];
        default:    need_q  <= need_q;
      endcase
    end
  end

  always_comb begin
    rd_map  = 1'b1;
    rd_word = 32'h0;
    case ({S_AXI_ARADDR_IN[5:2], 2'h0})
      `OFS_CTRL:   rd_word = {29'h0, dev_sel_q, settled_q};
      `OFS_STATUS: rd_word = {30'h0, resp_pend_q, link_ready_q};
      `OFS_LEFT:   rd_word = {12'h000, left_q};
      `OFS_RIGHT:  rd_word = {12'h000, right_q};
      `OFS_NEED:   rd_word = {22'h0, need_q};
      `OFS_VIEW:   rd_word = {13'h0, dac_pair, variable_rate_enable, dac_rate_q};
      default:     rd_map  = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0;
      S_AXI_RRESP_OUT  <= `RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT  <= rd_word;
      S_AXI_RRESP_OUT  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_drive(logic [3:0] slot);
    rise_evt && !frame_start && tx_state_q == ac_link_pkg::TX_SEND && tx_slot_q == slot;
  endsequence

  a_start_first_bit: assert property (frame_start |=>
    tx_state_q == ac_link_pkg::TX_SEND && tx_slot_q == 4'h0 && tx_bit_q == 5'h0F)
    else $error("frame start did not load tag bit 15");
  a_ready_bit_out: assert property (s_drive(4'h0) ##0 tx_bit_q == 5'h0F |=>
    SDATA_IN_OUT == tag_q[15])
    else $error("first tag bit is not the ready flag");
  a_ready_in_time: assert property (ready_cnt_q >= READY_CYCLES |=> link_ready_q)
    else $error("ready flag missing after settle limit");
  a_slot5_zero: assert property (s_drive(4'h5) |=> !SDATA_IN_OUT)
    else $error("slot 5 not zero");
  a_slot12_zero: assert property (s_drive(4'hC) |=> !SDATA_IN_OUT)
    else $error("slot 12 not zero");
  a_idle_line_zero: assert property (rise_evt && !frame_start &&
    tx_state_q == ac_link_pkg::TX_IDLE |=> !SDATA_IN_OUT)
    else $error("line not zero outside a frame");
  a_slot_boundary: assert property (s_drive(tx_slot_q) ##0 tx_bit_q == 5'h0 &&
    tx_slot_q < 4'hC |=> tx_slot_q == $past(tx_slot_q) + 4'h1 && tx_bit_q == 5'h13)
    else $error("slot boundary misplaced");
  a_fixed_rate_zero: assert property (!variable_rate_enable |-> slot_req == 10'h000)
    else $error("request flag set at fixed rate");
  a_reply_tags: assert property (frame_start && resp_pend_q && link_ready_q |=>
    tag_q[14] && tag_q[13] && !resp_pend_q)
    else $error("read reply not tagged in next frame");
  a_no_reply_tags: assert property (frame_start && !resp_pend_q |=>
    !tag_q[14] && !tag_q[13] && s2_q == 20'h00000)
    else $error("slot 1/2 tagged without reply");
  a_bus_write_resp: assert property (wr_go |=> S_AXI_BVALID_OUT)
    else $error("write response missing");

endmodule // ac_link_input_frame

// ---- verilog/ac_link_pkg.sv ----
// Types shared by the input frame builder
package ac_link_pkg;

  typedef enum logic [1:0] {
    PAIR_3_4,
    PAIR_6_9,
    PAIR_7_8,
    PAIR_10_11
  } slot_pair_type;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } tx_state_type;

endpackage

// ---- verilog/pin_sync.sv ----
// Two-flop synchroniser for the three link input pins
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [2:0] pins_in,
  output logic      [2:0] pins_out
);

  logic [2:0] meta_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q   <= 3'h0;
      pins_out <= 3'h0;
    end else begin
      meta_q   <= pins_in;
      pins_out <= meta_q;
    end
  end

endmodule // pin_sync
